/* design/mic_core.sv */
// 8-bit accumulator core: fetch, execute and instruction-cycle timing.
// Assumes program and data memories answer combinationally to the
// address outputs, and that data memory writes on the clock edge seen
// while the write strobe is high.
// Functional notes
// - Ordinary instructions finish in one instruction cycle.
// - Jump, call, exit, interrupt exit and table read take two cycles.
// - One instruction cycle is four system clocks.
// - Writing program counter low jumps and costs one extra cycle.
// - Taken skip costs one extra cycle, untaken skip costs none.
// - Add reports carry above 255, subtract reports borrow below 0.
// - Increment and decrement change by one, to memory or accumulator.
// - Logic and invert instructions set zero flag on zero result.
// - Rotates move bits by exactly one position left or right.
// - Rotate via carry moves the leaving bit into carry.
// - Subroutine exit resumes right after the calling instruction.
// - Conditional skips test a byte or a bit and skip the next one.
// - Bit set and clear alter only the addressed bit.
// - Table read fetches constant data from program memory.
// - Moves go memory to accumulator, back, and immediate to accumulator.
// - A dedicated instruction enters power-down.
`timescale 1ns/1ns
`include "mic_params.svh"

module mic_core #(
  parameter int PC_W = 11,
  parameter int STACK_D = 8
) (
  input logic clk,
  input logic reset,
  input logic wake_pin,
  input logic [15:0] prog_rdata,
  input logic [7:0] data_rdata,
  output logic [PC_W-1:0] prog_addr,
  output mic_pkg::mic_dmem_s dmem,
  output mic_pkg::mic_flags_s flags,
  output logic [7:0] acc,
  output logic power_down,
  output logic int_enable,
  output logic retire
);
  localparam int SP_W = $clog2(STACK_D);

  logic [1:0] phase;
  mic_pkg::mic_state_e state;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] redirect;
  logic [PC_W-1:0] tbl_addr;
  logic [15:0] ir;
  logic [7:0] opnd;
  logic [PC_W-1:0] stack [STACK_D];
  logic [SP_W-1:0] sp;
  logic wake_s1;
  logic wake_s2;

  // Decoded results of the current instruction
  logic [7:0] next_acc;
  mic_pkg::mic_flags_s next_flags;
  logic [7:0] res;
  logic wr_mem;
  logic taken;
  logic [PC_W-1:0] target;
  logic push;
  logic pop;

  wire [4:0] op = ir[15:11];
  wire [2:0] bsel = ir[10:8];
  wire to_mem = ir[8];
  wire [7:0] imm = ir[7:0];
  wire [PC_W-1:0] pc_inc = pc + PC_W'(1);
  wire last_ph = (phase == `MIC_PH_LAST);

  // 9-bit adder shared by add, subtract, increment and decrement
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // Instruction cycle sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Two-flop synchroniser for the wake pin
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end else begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
    end
  end

  // Execute decode, evaluated while the operand is stable
  always_comb begin
    logic [8:0] sum;
    sum = 9'h000;
    res = opnd;
    next_acc = acc;
    next_flags = flags;
    wr_mem = 1'b0;
    taken = 1'b0;
    target = pc_inc;
    push = 1'b0;
    pop = 1'b0;
    case (op)
      `MIC_OP_ADD, `MIC_OP_ADDX, `MIC_OP_ADC: begin
        sum = add9(acc, op == `MIC_OP_ADDX ? imm : opnd,
                   op == `MIC_OP_ADC ? flags.carry : 1'b0);
        res = sum[7:0];
        next_flags.carry = sum[8];
        next_flags.zero = (res == 8'h00);
        wr_mem = to_mem && op != `MIC_OP_ADDX;
      end
      `MIC_OP_SUB, `MIC_OP_SUBX, `MIC_OP_SBC: begin
        // Carry flag holds the borrow here: set when result went below 0
        sum = add9(acc, ~(op == `MIC_OP_SUBX ? imm : opnd),
                   op == `MIC_OP_SBC ? ~flags.carry : 1'b1);
        res = sum[7:0];
        next_flags.carry = ~sum[8];
        next_flags.zero = (res == 8'h00);
        wr_mem = to_mem && op != `MIC_OP_SUBX;
      end
      `MIC_OP_AND, `MIC_OP_ANDX, `MIC_OP_OR, `MIC_OP_ORX,
      `MIC_OP_XOR, `MIC_OP_XORX, `MIC_OP_INVERT: begin
        case (op)
          `MIC_OP_AND: res = acc & opnd;
          `MIC_OP_ANDX: res = acc & imm;
          `MIC_OP_OR: res = acc | opnd;
          `MIC_OP_ORX: res = acc | imm;
          `MIC_OP_XOR: res = acc ^ opnd;
          `MIC_OP_XORX: res = acc ^ imm;
          default: res = ~opnd;
        endcase
        next_flags.zero = (res == 8'h00);
        wr_mem = to_mem && !op[0];
      end
      `MIC_OP_INC, `MIC_OP_DEC: begin
        sum = add9(opnd, op == `MIC_OP_DEC ? 8'hff : 8'h00, op == `MIC_OP_INC);
        res = sum[7:0];
        next_flags.zero = (res == 8'h00);
        wr_mem = to_mem;
      end
      `MIC_OP_RR: begin
        res = {opnd[0], opnd[7:1]};
        wr_mem = to_mem;
      end
      `MIC_OP_RL: begin
        res = {opnd[6:0], opnd[7]};
        wr_mem = to_mem;
      end
      `MIC_OP_RRC: begin
        res = {flags.carry, opnd[7:1]};
        next_flags.carry = opnd[0];
        wr_mem = to_mem;
      end
      `MIC_OP_RLC: begin
        res = {opnd[6:0], flags.carry};
        next_flags.carry = opnd[7];
        wr_mem = to_mem;
      end
      `MIC_OP_MOVAM: res = opnd;
      `MIC_OP_MOVX: res = imm;
      `MIC_OP_MOVMA: begin
        res = acc;
        wr_mem = 1'b1;
      end
      `MIC_OP_BSET, `MIC_OP_BCLR: begin
        // Read-modify-write keeps the other seven bits
        res = opnd;
        res[bsel] = (op == `MIC_OP_BSET);
        wr_mem = 1'b1;
      end
      `MIC_OP_SZ: begin
        taken = (opnd == 8'h00);
        target = pc + PC_W'(2);
        wr_mem = to_mem && taken;
      end
      `MIC_OP_SNZ: begin
        taken = (opnd != 8'h00);
        target = pc + PC_W'(2);
      end
      `MIC_OP_SZB, `MIC_OP_SNZB: begin
        taken = opnd[bsel] ^ (op == `MIC_OP_SZB);
        target = pc + PC_W'(2);
      end
      `MIC_OP_JUMP: begin
        taken = 1'b1;
        target = ir[PC_W-1:0];
      end
      `MIC_OP_CALL: begin
        taken = 1'b1;
        push = 1'b1;
        target = ir[PC_W-1:0];
      end
      `MIC_OP_SYS: begin
        if (ir[2:0] == `MIC_SYS_EXIT || ir[2:0] == `MIC_SYS_IEXIT) begin
          taken = 1'b1;
          pop = 1'b1;
          target = stack[sp - SP_W'(1)];
        end
      end
      default: res = acc;
    endcase
    // Destination: accumulator unless the instruction stores to memory, is a skip or is a jump, call or system op
    if (!wr_mem && op != `MIC_OP_SZ && op != `MIC_OP_SNZ && op != `MIC_OP_SZB
        && op != `MIC_OP_SNZB && op < `MIC_OP_MOVMA || op == `MIC_OP_MOVX) begin
      next_acc = res;
    end
    // SZ with memory destination copies the byte to the accumulator too
    if (op == `MIC_OP_SZ && to_mem) begin
      next_acc = opnd;
      wr_mem = 1'b0;
    end
    // A store to program counter low turns into a jump
    if (wr_mem && dmem.addr == `MIC_PCL_ADDR) begin
      wr_mem = 1'b0;
      taken = 1'b1;
      target = {pc[PC_W-1:8], res};
    end
  end

  // Fetch addressing: program and table addresses, instruction and operand
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_addr <= `MIC_RESET_VEC;
      ir <= 16'h0000;
      opnd <= 8'h00;
    end else begin
      if (phase == 2'h0) begin
        prog_addr <= (state == mic_pkg::cs_table) ? tbl_addr : pc;
      end
      // Instruction fetched in a flush cycle is dropped here
      if (phase == 2'h1 && state == mic_pkg::cs_exec) begin
        ir <= prog_rdata;
      end
      if (phase == 2'h2) begin
        opnd <= (dmem.addr == `MIC_PCL_ADDR) ? pc[7:0] : data_rdata;
      end
    end
  end

  // Data memory port: one process owns the whole struct, so it has one driver
  // Write strobe lasts one clock and is seen at the following edge
  always_ff @(posedge clk) begin
    if (reset) begin
      dmem.addr <= 8'h00;
      dmem.we <= 1'b0;
      dmem.wdata <= 8'h00;
    end else begin
      // Address follows executed fetches only, so a flush keeps the old one
      if (phase == 2'h1 && state == mic_pkg::cs_exec) begin
        dmem.addr <= prog_rdata[7:0];
      end
      dmem.we <= last_ph && state == mic_pkg::cs_exec && wr_mem;
      if (last_ph && state == mic_pkg::cs_exec) begin
        dmem.wdata <= res;
      end
    end
  end

  // Accumulator, flags and table data
  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= 8'h00;
      flags <= '0;
    end else if (phase == 2'h1 && state == mic_pkg::cs_table) begin
      acc <= prog_rdata[7:0];
    end else if (last_ph && state == mic_pkg::cs_exec) begin
      acc <= next_acc;
      flags <= next_flags;
    end
  end

  // Program counter, redirect target and state
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= `MIC_RESET_VEC;
      redirect <= `MIC_RESET_VEC;
      tbl_addr <= `MIC_RESET_VEC;
      state <= mic_pkg::cs_exec;
      power_down <= 1'b0;
      int_enable <= 1'b0;
    end else if (last_ph) begin
      case (state)
        mic_pkg::cs_exec: begin
          pc <= pc_inc;
          if (taken) begin
            // Spend one cycle fetching and dropping the successor
            redirect <= target;
            state <= mic_pkg::cs_flush;
          end else if (op == `MIC_OP_SYS && ir[2:0] == `MIC_SYS_TABLE) begin
            tbl_addr <= {pc[PC_W-1:8], opnd};
            state <= mic_pkg::cs_table;
          end else if (op == `MIC_OP_SYS && ir[2:0] == `MIC_SYS_HALT) begin
            power_down <= 1'b1;
            state <= mic_pkg::cs_sleep;
          end
          if (op == `MIC_OP_SYS && ir[2:0] == `MIC_SYS_IEXIT) begin
            int_enable <= 1'b1;
          end
        end
        mic_pkg::cs_flush: begin
          pc <= redirect;
          state <= mic_pkg::cs_exec;
        end
        mic_pkg::cs_table: state <= mic_pkg::cs_exec;
        mic_pkg::cs_sleep: begin
          // Wake is sampled once per instruction cycle only
          if (wake_s2) begin
            power_down <= 1'b0;
            state <= mic_pkg::cs_exec;
          end
        end
        default: state <= mic_pkg::cs_exec;
      endcase
    end
  end

  // Return stack; overflow wraps silently, as on small cores
  always_ff @(posedge clk) begin
    if (reset) begin
      sp <= '0;
    end else if (last_ph && state == mic_pkg::cs_exec) begin
      if (push) begin
        stack[sp] <= pc_inc;
        sp <= sp + SP_W'(1);
      end else if (pop) begin
        sp <= sp - SP_W'(1);
      end
    end
  end

  // Retire pulse marks the end of an executed instruction cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      retire <= 1'b0;
    end else begin
      retire <= last_ph && state == mic_pkg::cs_exec;
    end
  end

  // Checks
  property p_phase;
    @(posedge clk) disable iff (reset) last_ph |=> phase == 2'h0;
  endproperty
  a_phase: assert property (p_phase) else $error("phase did not wrap");

  property p_gap;
    @(posedge clk) disable iff (reset) retire |=> (!retire)[*3];
  endproperty
  a_gap: assert property (p_gap) else $error("retire closer than 4 clocks");

  property p_plain;
    @(posedge clk) disable iff (reset) retire && state == mic_pkg::cs_exec |-> ##4 retire;
  endproperty
  a_plain: assert property (p_plain) else $error("plain instruction not 1 cycle");

  property p_taken;
    @(posedge clk) disable iff (reset)
      retire && state == mic_pkg::cs_flush |-> ##1 (!retire)[*7] ##1 retire;
  endproperty
  a_taken: assert property (p_taken) else $error("taken flow not 2 cycles");

  property p_table;
    @(posedge clk) disable iff (reset)
      retire && state == mic_pkg::cs_table |-> ##2 acc == $past(prog_rdata[7:0]) ##6 retire;
  endproperty
  a_table: assert property (p_table) else $error("table read wrong");

  property p_pcl;
    @(posedge clk) disable iff (reset) dmem.we |-> dmem.addr != `MIC_PCL_ADDR;
  endproperty
  a_pcl: assert property (p_pcl) else $error("pcl reached data memory");

  property p_halt;
    // The halt's own retire falls in the first clock of power-down
    @(posedge clk) disable iff (reset) power_down && $past(power_down) |-> !retire;
  endproperty
  a_halt: assert property (p_halt) else $error("retired while asleep");

  property p_zero;
    @(posedge clk) disable iff (reset)
      retire && (op == `MIC_OP_ANDX || op == `MIC_OP_XORX) |-> flags.zero == (acc == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_inc;
    @(posedge clk) disable iff (reset)
      retire && op == `MIC_OP_INC && !to_mem |-> acc == opnd + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_rlc;
    @(posedge clk) disable iff (reset)
      retire && op == `MIC_OP_RLC && !to_mem |-> flags.carry == opnd[7] && acc[7:1] == opnd[6:0];
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate via carry wrong");

  c_taken: cover property (@(posedge clk) retire && state == mic_pkg::cs_flush);
  c_table: cover property (@(posedge clk) retire && state == mic_pkg::cs_table);
  c_sleep: cover property (@(posedge clk) power_down ##1 !power_down);
endmodule

/* design/mic_params.svh */
// Constants of the instruction core: timing, opcodes, mapped addresses.
// Assumes inclusion by bare name from the core; definitions only.
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH
`define MIC_CYC_CLKS 4
`define MIC_PH_LAST 2'h3
`define MIC_PCL_ADDR 8'h06
`define MIC_RESET_VEC 11'h000
// Opcode field, instruction bits 15:11
`define MIC_OP_ADD 5'h00
`define MIC_OP_ADDX 5'h01
`define MIC_OP_ADC 5'h02
`define MIC_OP_SUB 5'h03
`define MIC_OP_SUBX 5'h04
`define MIC_OP_SBC 5'h05
`define MIC_OP_AND 5'h06
`define MIC_OP_ANDX 5'h07
`define MIC_OP_OR 5'h08
`define MIC_OP_ORX 5'h09
`define MIC_OP_XOR 5'h0a
`define MIC_OP_XORX 5'h0b
`define MIC_OP_INVERT 5'h0c
`define MIC_OP_INC 5'h0d
`define MIC_OP_DEC 5'h0e
`define MIC_OP_RR 5'h0f
`define MIC_OP_RL 5'h10
`define MIC_OP_RRC 5'h11
`define MIC_OP_RLC 5'h12
`define MIC_OP_MOVAM 5'h13
`define MIC_OP_MOVMA 5'h14
`define MIC_OP_MOVX 5'h15
`define MIC_OP_BSET 5'h16
`define MIC_OP_BCLR 5'h17
`define MIC_OP_SZ 5'h18
`define MIC_OP_SNZ 5'h19
`define MIC_OP_SZB 5'h1a
`define MIC_OP_SNZB 5'h1b
`define MIC_OP_JUMP 5'h1c
`define MIC_OP_CALL 5'h1d
`define MIC_OP_SYS 5'h1e
// System sub-codes, instruction bits 2:0
`define MIC_SYS_NOP 3'h0
`define MIC_SYS_EXIT 3'h1
`define MIC_SYS_IEXIT 3'h2
`define MIC_SYS_TABLE 3'h3
`define MIC_SYS_HALT 3'h4
`endif

/* design/mic_pkg.sv */
// Types shared by the instruction core and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package mic_pkg;
  typedef enum {cs_exec, cs_flush, cs_table, cs_sleep} mic_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } mic_dmem_s;
  typedef struct packed {
    logic zero;
    logic carry;
  } mic_flags_s;
endpackage

/* test/mic_mem_model.sv */
// Behavioural program and data memories facing the instruction core.
// Assumes the bench fills both arrays by hierarchical write during reset.
`timescale 1ns/1ns
module mic_mem_model #(
  parameter int PC_W = 11
) (
  input logic clk,
  input logic [PC_W-1:0] prog_addr,
  input mic_pkg::mic_dmem_s dmem,
  output logic [15:0] prog_rdata,
  output logic [7:0] data_rdata
);
  logic [15:0] prog_mem [0:(1<<PC_W)-1];
  logic [7:0] data_mem [0:255];
  // Both reads answer combinationally, as the core expects
  assign prog_rdata = prog_mem[prog_addr];
  assign data_rdata = data_mem[dmem.addr];
  // Write lands on the edge that sees the strobe high
  always @(posedge clk) begin
    if (dmem.we === 1'b1) begin
      data_mem[dmem.addr] <= dmem.wdata;
    end
  end
endmodule

/* test/mic_instruction_timing_exec_bench.sv */
// Self-checking bench: runs short programs and times each retire.
// Assumes the core and the memory model; programs are preloaded in reset.
`timescale 1ns/1ns
`include "mic_params.svh"
module mic_instruction_timing_exec_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wake_pin = 1'b0;
  logic [15:0] prog_rdata;
  logic [7:0] data_rdata;
  logic [10:0] prog_addr;
  mic_pkg::mic_dmem_s dmem;
  mic_pkg::mic_flags_s flags;
  logic [7:0] acc;
  logic power_down;
  logic int_enable;
  logic retire;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int nret = 0;
  int rt [0:31];
  logic [7:0] ra [0:31];
  mic_pkg::mic_flags_s rf [0:31];

  mic_core mic_core_inst (.clk(clk), .reset(reset), .wake_pin(wake_pin),
    .prog_rdata(prog_rdata), .data_rdata(data_rdata), .prog_addr(prog_addr),
    .dmem(dmem), .flags(flags), .acc(acc), .power_down(power_down),
    .int_enable(int_enable), .retire(retire));
  mic_mem_model mic_mem_model_inst (.clk(clk), .prog_addr(prog_addr),
    .dmem(dmem), .prog_rdata(prog_rdata), .data_rdata(data_rdata));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Log time, accumulator and flags of the first 32 retires
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reset === 1'b0 && retire === 1'b1 && nret < 32) begin
      rt[nret] <= cyc;
      ra[nret] <= acc;
      rf[nret] <= flags;
      nret <= nret + 1;
    end
  end

  function automatic logic [15:0] w(logic [4:0] op, logic [2:0] b, logic [7:0] m);
    return {op, b, m};
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Holds reset 16 cycles while the program is loaded
  task automatic load(logic [15:0] p [$], logic [7:0] da [$], logic [7:0] dv [$]);
    @(negedge clk);
    reset = 1'b1;
    for (int i = 0; i < 2048; i++) mic_mem_model_inst.prog_mem[i] = 16'hf000;
    for (int i = 0; i < 256; i++) mic_mem_model_inst.data_mem[i] = 8'h00;
    foreach (p[i]) mic_mem_model_inst.prog_mem[i] = p[i];
    foreach (da[i]) mic_mem_model_inst.data_mem[da[i]] = dv[i];
    repeat (16) @(negedge clk);
    nret = 0;
    reset = 1'b0;
  endtask

  task automatic wait_ret(int n);
    for (int i = 0; i < 600 && nret < n; i++) @(negedge clk);
    if (nret < n) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic gaps(int g [$]);
    foreach (g[i]) check(16'(rt[i+1] - rt[i]), 16'(g[i]));
  endtask

  // Jump and skips; skipped words must never reach the accumulator
  task automatic test_branch;
    load('{w(`MIC_OP_MOVX, 3'h0, 8'h05), w(`MIC_OP_JUMP, 3'h0, 8'h04),
      w(`MIC_OP_MOVX, 3'h0, 8'h77), 16'hf000, w(`MIC_OP_SZ, 3'h0, 8'h20),
      w(`MIC_OP_MOVX, 3'h0, 8'h99), w(`MIC_OP_SNZ, 3'h0, 8'h20),
      w(`MIC_OP_SZB, 3'h1, 8'h21), w(`MIC_OP_SNZB, 3'h1, 8'h21),
      w(`MIC_OP_MOVX, 3'h0, 8'h55)}, '{8'h21}, '{8'h02});
    wait_ret(7);
    gaps('{4, 8, 8, 4, 4, 8});
    for (int i = 0; i < 7; i++) check(16'(ra[i]), 16'h0005);
  endtask

  // Call, both exits, table read, program counter low store, moves
  task automatic test_call;
    // Table byte address lives at an m whose low bits carry the table sub-code
    load('{w(`MIC_OP_CALL, 3'h0, 8'h08), w(`MIC_OP_CALL, 3'h0, 8'h10),
      w(`MIC_OP_SYS, 3'h0, 8'h2b), w(`MIC_OP_MOVMA, 3'h0, 8'h25),
      w(`MIC_OP_MOVX, 3'h0, 8'h0c), w(`MIC_OP_MOVMA, 3'h0, 8'h06), 16'hf000, 16'hf000,
      w(`MIC_OP_MOVX, 3'h0, 8'h10), w(`MIC_OP_SYS, 3'h0, 8'h01), 16'hf000,
      16'hf000, w(`MIC_OP_MOVAM, 3'h0, 8'h23), w(`MIC_OP_MOVMA, 3'h0, 8'h24),
      16'hf000, 16'hf000, w(`MIC_OP_SYS, 3'h0, 8'h02)},
      '{8'h2b, 8'h23}, '{8'h30, 8'h5a});
    mic_mem_model_inst.prog_mem[8'h30] = 16'h12ab;
    wait_ret(12);
    gaps('{8, 4, 8, 8, 8, 8, 4, 4, 8, 4, 4});
    check(16'(ra[1]), 16'h0010);
    // Table data lands one clock after the table retire, so look one retire on
    check(16'(ra[6]), 16'h00ab);
    check(16'(ra[9]), 16'h005a);
    check(16'(int_enable), 16'h0001);
    check(16'(mic_mem_model_inst.data_mem[8'h24]), 16'h005a);
    check(16'(mic_mem_model_inst.data_mem[8'h25]), 16'h00ab);
    check(16'(mic_mem_model_inst.data_mem[8'h06]), 16'h0000);
  endtask

  // Arithmetic, logic, rotates, increments and bit operations back to back
  task automatic test_alu;
    logic [7:0] ea [$];
    ea = '{8'hff, 8'h00, 8'hff, 8'hf0, 8'h00, 8'h81, 8'h40, 8'h03,
      8'hc0, 8'h03, 8'h03, 8'hff, 8'h00, 8'h82, 8'h82, 8'h82};
    load('{w(`MIC_OP_MOVX, 3'h0, 8'hff), w(`MIC_OP_ADDX, 3'h0, 8'h01),
      w(`MIC_OP_SUBX, 3'h0, 8'h01), w(`MIC_OP_SUBX, 3'h0, 8'h0f),
      w(`MIC_OP_ANDX, 3'h0, 8'h0f), w(`MIC_OP_ORX, 3'h0, 8'h81),
      w(`MIC_OP_RRC, 3'h0, 8'h25), w(`MIC_OP_RLC, 3'h0, 8'h25),
      w(`MIC_OP_RR, 3'h0, 8'h25), w(`MIC_OP_RL, 3'h0, 8'h25),
      w(`MIC_OP_INC, 3'h1, 8'h25), w(`MIC_OP_DEC, 3'h0, 8'h26),
      w(`MIC_OP_INVERT, 3'h0, 8'h27), w(`MIC_OP_XOR, 3'h0, 8'h25),
      w(`MIC_OP_BSET, 3'h0, 8'h28), w(`MIC_OP_BCLR, 3'h7, 8'h28)},
      '{8'h25, 8'h27, 8'h28}, '{8'h81, 8'hff, 8'ha0});
    wait_ret(17);
    for (int i = 0; i < 16; i++) check(16'(ra[i]), 16'(ea[i]));
    for (int i = 0; i < 16; i++) check(16'(rt[i+1] - rt[i]), 16'h0004);
    check(16'({rf[1].carry, rf[2].carry, rf[3].carry}), 16'h0006);
    check(16'({rf[6].carry, rf[7].carry}), 16'h0003);
    check(16'({rf[4].zero, rf[5].zero, rf[12].zero, rf[13].zero}), 16'h000a);
    check(16'(mic_mem_model_inst.data_mem[8'h25]), 16'h0082);
    check(16'(mic_mem_model_inst.data_mem[8'h28]), 16'h0021);
    check(16'(mic_mem_model_inst.data_mem[8'h26]), 16'h0000);
  endtask

  task automatic wait_pd(logic v);
    for (int i = 0; i < 100 && power_down !== v; i++) @(negedge clk);
    check(16'(power_down), 16'(v));
  endtask

  // Halt stops retiring until the wake pin is raised; memory arithmetic follows
  task automatic test_halt;
    int n;
    logic [7:0] ea [$];
    ea = '{8'h22, 8'h42, 8'hf2, 8'hf2, 8'h33, 8'h00};
    load('{w(`MIC_OP_MOVX, 3'h0, 8'h11), w(`MIC_OP_SYS, 3'h0, 8'h04),
      w(`MIC_OP_MOVX, 3'h0, 8'h22), w(`MIC_OP_INC, 3'h0, 8'h30),
      w(`MIC_OP_SUB, 3'h0, 8'h31), w(`MIC_OP_SBC, 3'h1, 8'h31),
      w(`MIC_OP_ADC, 3'h0, 8'h30), w(`MIC_OP_XORX, 3'h0, 8'h33)},
      '{8'h30, 8'h31}, '{8'h41, 8'h50});
    wait_pd(1'b1);
    // The halt itself is logged one clock after power-down rises
    @(negedge clk);
    n = nret;
    repeat (40) @(negedge clk);
    check(16'(nret), 16'(n));
    check(16'(acc), 16'h0011);
    wake_pin = 1'b1;
    wait_pd(1'b0);
    wake_pin = 1'b0;
    wait_ret(n + 6);
    for (int i = 0; i < 6; i++) check(16'(ra[n+i]), 16'(ea[i]));
    check(16'({rf[n+1].carry, rf[n+2].carry, rf[n+3].carry, rf[n+4].carry,
      rf[n+5].carry}), 16'h000b);
    check(16'({rf[n+1].zero, rf[n+2].zero, rf[n+3].zero, rf[n+4].zero,
      rf[n+5].zero}), 16'h0001);
    check(16'(mic_mem_model_inst.data_mem[8'h31]), 16'h00a1);
  endtask

  // Main sequence
  initial begin
    test_branch();
    test_call();
    test_alu();
    test_halt();
    complete_run();
  end
endmodule
